// ---- wcc_pkg.sv ----
// Constants, types and helpers shared by the wakeup and clock control block
package wcc_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] WAKE_EN_IDX = 8'h2b;
  localparam logic [7:0] CLK_CTRL_IDX = 8'h2c;
  localparam logic [7:0] IRQ_STS_IDX = 8'h30;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h31;
  localparam logic [9:0] WAKE_EN_ADDR = {WAKE_EN_IDX, 2'b00};
  localparam logic [9:0] CLK_CTRL_ADDR = {CLK_CTRL_IDX, 2'b00};
  localparam logic [9:0] IRQ_STS_ADDR = {IRQ_STS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

  // Wakeup enable fields
  localparam int WAKE_REMOVAL_BIT = 2;
  localparam int WAKE_INSERT_BIT = 1;
  localparam int WAKE_CARDINT_BIT = 0;
  localparam logic [7:0] WAKE_EN_WMASK = 8'h07;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;

  // Clock control fields
  localparam int FREQ_SEL_LSB = 8;
  localparam int FREQ_SEL_MSB = 15;
  localparam int FREQ_UPPER_LSB = 6;
  localparam int FREQ_UPPER_MSB = 7;
  localparam int CLK_GEN_SEL_BIT = 5;
  localparam int SD_CLK_EN_BIT = 2;
  localparam int INT_CLK_STABLE_BIT = 1;
  localparam int INT_CLK_EN_BIT = 0;
  localparam logic [15:0] CLK_CTRL_WMASK = 16'hffe5;
  localparam logic [15:0] CLK_CTRL_RESET = 16'h0000;

  // Internal clock settling time
  localparam int STABLE_TIME_NS = 100;
  localparam int STABLE_CYCLES = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_STABLE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  typedef struct packed {
    logic removal;
    logic insertion;
    logic card_int;
  } wcc_card_flags_t;

  typedef enum logic [2:0] {
    CLK_OFF = 3'b001,
    CLK_SETTLE = 3'b010,
    CLK_READY = 3'b100
  } wcc_clk_state_t;

  // Word address match on all ten word address bits
  function automatic logic wcc_hit(input logic [9:0] addr, input logic [9:0] reg_addr);
    wcc_hit = (addr == reg_addr);
  endfunction

  // Half period of the card clock in base cycles; field value 0 runs at half rate
  function automatic logic [7:0] wcc_half(input logic [7:0] sel);
    wcc_half = (sel == 8'h00) ? 8'h01 : sel;
  endfunction

endpackage

// ---- wcc_wakeup_clock_ctrl.sv ----
// Wakeup enable and card clock control registers with APB access
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - 8-bit wakeup enable register at index 2Bh; bits 7-3 reserved, read zero.
// - Bit 2 set: card removal flag raises a wakeup; clear: no removal wakeup.
// - Bit 1 set: card insertion flag raises a wakeup; clear: disabled.
// - Card wake support flag never gates, clears or alters bits 2 and 1.
// - Bit 0 set: card interrupt flag raises a wakeup; clear: disabled.
// - 16-bit clock control at index 2Ch; bits 15-8 frequency select, read/write.
// - Frequency select field sets the card clock output frequency.
// - Divided mode: divisor is twice the field value, e.g. 80h gives 256.
module wcc_wakeup_clock_ctrl
  import wcc_pkg::*;
#(
  parameter int STABLE_CNT = STABLE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Normal interrupt status flags from the controller
  input wire wcc_card_flags_t card_flags,
  // Wakeup, card clock and interrupt
  output logic wakeup_req,
  output logic sdclk,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [9:0] word_addr;
  logic setup_phase;
  logic wr_access;
  logic hit_wake;
  logic hit_clk;
  logic hit_sts;
  logic hit_mask;
  logic [31:0] rd_mux;

  assign word_addr = paddr[11:2];
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign hit_wake = wcc_hit(word_addr, WAKE_EN_ADDR[9:0] >> 2);
  assign hit_clk = wcc_hit(word_addr, CLK_CTRL_ADDR[9:0] >> 2);
  assign hit_sts = wcc_hit(word_addr, IRQ_STS_ADDR[9:0] >> 2);
  assign hit_mask = wcc_hit(word_addr, IRQ_MASK_ADDR[9:0] >> 2);
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] wake_en_q;
  logic [15:0] clk_ctrl_q;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_sts_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  wcc_clk_state_t clk_state_q;
  logic [15:0] settle_q;
  logic [7:0] div_cnt_q;
  logic sdclk_q;
  logic wakeup_q;
  logic wake_any;
  logic stable;
  logic [7:0] half;

  // Reserved bits are never stored; no other input touches these bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_q <= WAKE_EN_RESET;
    end else if (wr_access && hit_wake) begin
      wake_en_q <= pwdata[7:0] & WAKE_EN_WMASK;
    end
  end

  // Stable bit is not stored; it reflects the clock state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_q <= CLK_CTRL_RESET;
    end else if (wr_access && hit_clk) begin
      clk_ctrl_q <= pwdata[15:0] & CLK_CTRL_WMASK;
    end
  end

  assign stable = (clk_state_q == CLK_READY);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_wake) begin
      rd_mux[7:0] = wake_en_q;
    end else if (hit_clk) begin
      rd_mux[15:0] = clk_ctrl_q;
      rd_mux[INT_CLK_STABLE_BIT] = stable;
    end else if (hit_sts) begin
      rd_mux[IRQ_W-1:0] = irq_sts_q;
    end else if (hit_mask) begin
      rd_mux[IRQ_W-1:0] = irq_mask_q;
    end
  end

  // Read data and error are captured in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~(hit_wake | hit_clk | hit_sts | hit_mask);
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup request

  // Enabled flags of removal, insertion and card interrupt
  assign wake_any = |(wake_en_q[2:0] & card_flags);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_q <= 1'b0;
    end else begin
      wakeup_q <= wake_any;
    end
  end

  assign wakeup_req = wakeup_q;

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock settling

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_state_q <= CLK_OFF;
      settle_q <= 16'h0000;
    end else begin
      case (clk_state_q)
        CLK_OFF: begin
          settle_q <= 16'h0000;
          if (clk_ctrl_q[INT_CLK_EN_BIT]) begin
            clk_state_q <= CLK_SETTLE;
          end
        end
        CLK_SETTLE: begin
          if (!clk_ctrl_q[INT_CLK_EN_BIT]) begin
            clk_state_q <= CLK_OFF;
          end else if (settle_q == 16'(STABLE_CNT - 1)) begin
            clk_state_q <= CLK_READY;
          end else begin
            settle_q <= settle_q + 16'h0001;
          end
        end
        CLK_READY: begin
          if (!clk_ctrl_q[INT_CLK_EN_BIT]) begin
            clk_state_q <= CLK_OFF;
          end
        end
        default: begin
          clk_state_q <= CLK_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card clock divider

  assign half = wcc_half(clk_ctrl_q[FREQ_SEL_MSB:FREQ_SEL_LSB]);

  // Toggling every half cycles gives a period of twice the field; field value 0 gives a period of 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 8'h00;
      sdclk_q <= 1'b0;
    end else if (!(stable && clk_ctrl_q[SD_CLK_EN_BIT])) begin
      div_cnt_q <= 8'h00;
      sdclk_q <= 1'b0;
    end else if (div_cnt_q >= half - 8'h01) begin
      div_cnt_q <= 8'h00;
      sdclk_q <= ~sdclk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  assign sdclk = sdclk_q;

  // Cycles the card clock has run since the last control write, saturating at 15; checks the divider
  logic [3:0] run_age_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_age_q <= 4'h0;
    end else if (!(stable && clk_ctrl_q[SD_CLK_EN_BIT]) || (wr_access && hit_clk)) begin
      run_age_q <= 4'h0;
    end else if (run_age_q != 4'hf) begin
      run_age_q <= run_age_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic wake_prev_q;
  logic stable_prev_q;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev_q <= 1'b0;
      stable_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wakeup_q;
      stable_prev_q <= stable;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_WAKE_BIT] = wakeup_q & ~wake_prev_q;
    irq_ev[IRQ_STABLE_BIT] = stable & ~stable_prev_q;
    irq_clr = (wr_access && hit_sts) ? pwdata[IRQ_W-1:0] : '0;
    // A new event wins over a clear in the same cycle
    irq_sts_d = (irq_sts_q & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= IRQ_RESET;
    end else begin
      irq_sts_q <= irq_sts_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_access && hit_mask) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_sts_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wake_en_write: assert property (
    wr_access && hit_wake |=> wake_en_q == ($past(pwdata[7:0]) & 8'h07))
    else $error("wakeup enable write not stored");

  a_wake_rsvd_zero: assert property (
    psel && !penable && !pwrite && hit_wake |=> prdata[31:3] == 29'h0)
    else $error("wakeup enable reserved bits read nonzero");

  a_wake_removal: assert property (
    wake_en_q[WAKE_REMOVAL_BIT] && card_flags.removal |=> wakeup_req)
    else $error("removal wakeup missing");

  a_wake_insertion: assert property (
    wake_en_q[WAKE_INSERT_BIT] && card_flags.insertion |=> wakeup_req)
    else $error("insertion wakeup missing");

  a_wake_hold: assert property (
    !(wr_access && hit_wake) |=> $stable(wake_en_q[2:1]))
    else $error("removal or insertion enable changed without a write");

  a_wake_cardint: assert property (
    wake_en_q[WAKE_CARDINT_BIT] && card_flags.card_int |=> wakeup_req)
    else $error("card interrupt wakeup missing");

  a_wake_none: assert property (
    (wake_en_q[2:0] & card_flags) == 3'b000 |=> !wakeup_req)
    else $error("wakeup without enabled flag");

  a_freq_write: assert property (
    wr_access && hit_clk |=> clk_ctrl_q[15:8] == $past(pwdata[15:8]))
    else $error("frequency select write not stored");

  a_clk_layout: assert property (
    clk_ctrl_q[4:3] == 2'b00 && clk_ctrl_q[1] == 1'b0)
    else $error("reserved or stable bit stored in clock control");

  a_stable_after_en: assert property (
    stable |-> $past(clk_ctrl_q[INT_CLK_EN_BIT]) && $past(clk_ctrl_q[INT_CLK_EN_BIT], 2))
    else $error("stable without internal clock enable");

  a_stable_drop: assert property (
    !clk_ctrl_q[INT_CLK_EN_BIT] |=> !stable)
    else $error("stable still set after internal clock disable");

  a_sdclk_divide: assert property (
    $rose(sdclk) && clk_ctrl_q[15:8] == 8'h02 && run_age_q >= 4'h6
      |-> !$past(sdclk) && !$past(sdclk, 2) && $past(sdclk, 3) && $past(sdclk, 4))
    else $error("divide by four period wrong");

  a_sdclk_gated: assert property (
    !clk_ctrl_q[SD_CLK_EN_BIT] |=> !sdclk)
    else $error("card clock runs while disabled");

  a_irq_level: assert property (
    $past(wr_access && hit_sts && pwdata[0]) && !$past(irq_ev[0]) |-> !irq_sts_q[0])
    else $error("wakeup status not cleared");

  a_sts_set_wins: assert property (
    irq_ev[IRQ_WAKE_BIT] |=> irq_sts_q[IRQ_WAKE_BIT])
    else $error("wakeup status event lost");

  a_err_unmapped: assert property (
    psel && !penable && !(hit_wake || hit_clk || hit_sts || hit_mask) |=> pslverr)
    else $error("unmapped access without error");

  a_err_mapped: assert property (
    psel && !penable && (hit_wake || hit_clk) |=> !pslverr)
    else $error("mapped access flagged as error");

  c_wake_removal: cover property (wake_en_q[2] && card_flags.removal ##1 wakeup_req);
  c_clk_ready: cover property ($rose(stable));
  c_sdclk_toggle: cover property ($rose(sdclk) ##[1:300] $fell(sdclk));
  c_irq_raise: cover property ($rose(irq));
  c_wake_cardint: cover property (wake_en_q[0] && card_flags.card_int ##1 wakeup_req);

endmodule

// ---- wcc_card_model.sv ----
// Card-side model: drives the card status flags and times the card clock
`timescale 1ns/1ps
module wcc_card_model
  import wcc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Card side
  input wire logic sdclk,
  input wire logic [2:0] flags_cmd,
  output wcc_card_flags_t card_flags,
  output logic wake_support,
  output int rise_gap
);
  logic prev_q;
  int cnt_q;
  // Card reports wake support, so card interrupt wakeup may be armed
  assign wake_support = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) card_flags <= '0;
    else card_flags <= flags_cmd;
  end
  // Pclk cycles between two rising card clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= 0;
      rise_gap <= 0;
    end else begin
      prev_q <= sdclk;
      cnt_q <= (sdclk && !prev_q) ? 1 : cnt_q + 1;
      if (sdclk && !prev_q) rise_gap <= cnt_q;
    end
  end
endmodule

// ---- wakeup_and_clock_control_bench.sv ----
// Self-checking bench for the wakeup and card clock control block
`timescale 1ns/1ps
module wakeup_and_clock_control_bench
  import wcc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wakeup_req, sdclk, irq;
  logic wake_support;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic [2:0] flags_cmd;
  logic er;
  wcc_card_flags_t card_flags;
  int rise_gap, err_total, num_checks, en, fl, f;
  logic [31:0] seed;
  logic [7:0] fields [3] = '{8'h02, 8'h04, 8'h80};
  wcc_wakeup_clock_ctrl #(.STABLE_CNT(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_flags(card_flags), .wakeup_req(wakeup_req),
    .sdclk(sdclk), .irq(irq));
  wcc_card_model i_card (.pclk(pclk), .presetn(presetn), .sdclk(sdclk), .flags_cmd(flags_cmd),
    .card_flags(card_flags), .wake_support(wake_support), .rise_gap(rise_gap));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, waiting for pready in the access phase
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, flags_cmd} = '0;
    presetn = 1'b0;
    seed = 32'd23;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, WAKE_EN_ADDR, 0);
    chk("wake_en reset", rd, 0);
    apb(0, CLK_CTRL_ADDR, 0);
    chk("clk_ctrl reset", rd, 0);
    apb(0, 10'h004, 0);
    chk("pready", pready, 1);
    chk("unmapped read data", rd, 0);
    chk("unmapped read err", er, 1);
    apb(1, 10'h008, 32'hffff);
    chk("unmapped write err", er, 1);
    // Random enables and flags against the expected wakeup level
    for (int i = 0; i < 16; i++) begin
      wd = rnd();
      en = (wake_support === 1'b1) ? wd[2:0] : wd[2:0] & 3'b110;
      apb(1, WAKE_EN_ADDR, {wd[31:3], en[2:0]});
      apb(0, WAKE_EN_ADDR, 0);
      chk("wake_en read", rd, en);
      chk("wake_en err", er, 0);
      fl = rnd() & 7;
      flags_cmd <= fl[2:0];
      settle(3);
      chk("wakeup_req", wakeup_req, |(en & fl));
    end
    // Interrupt: raise, mask, unmask and clear
    flags_cmd <= 3'b000;
    apb(1, WAKE_EN_ADDR, 32'h4);
    apb(1, IRQ_STS_ADDR, 32'h3);
    apb(1, IRQ_MASK_ADDR, 32'h1);
    settle(2);
    chk("irq idle", irq, 0);
    @(posedge pclk);
    flags_cmd <= 3'b100;
    settle(4);
    chk("irq raised", {wakeup_req, irq}, 3);
    apb(0, IRQ_STS_ADDR, 0);
    chk("irq status", rd[1:0], 1);
    apb(1, IRQ_MASK_ADDR, 0);
    settle(0);
    chk("irq masked", irq, 0);
    apb(1, IRQ_MASK_ADDR, 1);
    flags_cmd <= 3'b000;
    settle(0);
    chk("irq unmasked", irq, 1);
    apb(1, IRQ_STS_ADDR, 1);
    settle(0);
    chk("irq cleared", irq, 0);
    // Clock control layout and divided card clock
    apb(1, CLK_CTRL_ADDR, 32'hfffe);
    apb(0, CLK_CTRL_ADDR, 0);
    chk("clk_ctrl rw", rd, 32'hffe4);
    foreach (fields[k]) begin
      f = fields[k];
      apb(1, CLK_CTRL_ADDR, (f << 8) | 5);
      settle(12);
      apb(0, CLK_CTRL_ADDR, 0);
      chk("clk stable", rd, (f << 8) | 7);
      settle(6 * f + 20);
      chk("sdclk period", rise_gap, 2 * f);
    end
    apb(1, CLK_CTRL_ADDR, 32'h0204);
    settle(2);
    chk("sdclk stopped", sdclk, 0);
    final_report();
  end
endmodule
